// [core/eag_regs.svh]
// Constants of the effective address generator: page bytes, field positions, reset values.
// Assumes an 8-bit data path and a 16-bit address space.
`ifndef EAG_REGS_SVH
`define EAG_REGS_SVH

`define EAG_ZERO_PAGE_HI    8'h00
`define EAG_SPECIAL_PAGE_HI 8'hff
`define EAG_BITNUM_MSB      7
`define EAG_BITNUM_LSB      5
`define EAG_ADDR_RST        16'h0000
`define EAG_DATA_RST        8'h00
`define EAG_ONE_BIT_MASK    8'h01
`define EAG_PTR_STEP16      16'h0001
`define EAG_PTR_STEP8       8'h01

`endif

// [core/eag_pkg.sv]
// Types of the effective address generator: addressing modes and sequencer states.
// Assumes the instruction decoder outside maps each opcode to one mode_t.
package eag_pkg;

  typedef enum logic [3:0] {
    MODE_ABS_Y,
    MODE_IMPLIED,
    MODE_REL,
    MODE_IND_X,
    MODE_IND_Y,
    MODE_IND_ABS,
    MODE_ZP_IND,
    MODE_SPECIAL,
    MODE_ZP_BIT,
    MODE_ACC_BIT,
    MODE_ACC_BIT_REL,
    MODE_ZP_BIT_REL
  } mode_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_LO,
    ST_WT_LO,
    ST_RD_HI,
    ST_WT_HI,
    ST_FIN
  } state_t;

endpackage : eag_pkg

// [core/ea_adder.sv]
// Address adder: 16-bit base plus an 8-bit offset, unsigned or sign-extended.
// Assumes purely combinational use inside the address generator.
`timescale 1ns/1ps
`default_nettype none

module ea_adder #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8
) (
  input  wire logic [ADDR_W-1:0] base_in,
  input  wire logic [DATA_W-1:0] offset_in,
  input  wire logic              signed_in,
  output logic      [ADDR_W-1:0] sum_out
);

  wire logic [ADDR_W-1:0] ext_w;

  // Carry runs into the high byte; sign fill only for branch displacements
  assign ext_w   = {{(ADDR_W-DATA_W){signed_in & offset_in[DATA_W-1]}}, offset_in};
  assign sum_out = base_in + ext_w;

endmodule : ea_adder

`default_nettype wire

// [core/effective_address_generator.sv]
// Effective address generator: forms data addresses, jump and branch targets per mode.
// Assumes memory answers a read strobe with mem_rdata_in valid in the following cycle.
//
// Function
// [RULE1] Absolute-Y: base from operand bytes, low then high, plus Y.
// [RULE2] Implied mode has no address operand; opcode alone fixes the target.
// [RULE3] Taken relative branch adds operand to program counter for next fetch.
// [RULE4] Untaken relative or bit branch continues with the following instruction.
// [RULE5] Pre-indexed: operand plus X modulo 256 as zero-page pointer.
// [RULE6] Pre-indexed: low byte at pointer, high byte at next zero-page location.
// [RULE7] Post-indexed: zero-page pointer pair read, then Y added.
// [RULE8] Indirect jump: operand pointer, low there, high at following address.
// [RULE9] Software never places an indirect jump pointer at a page end.
// [RULE10] Zero-page indirect jump/call: low at operand, high at next zero-page byte.
// [RULE11] Special page: operand low byte, FF hex high byte.
// [RULE12] Zero-page bit ops address operand in page zero; bit from opcode 7:5.
// [RULE13] Accumulator bit ops change only the opcode-selected bit.
// [RULE14] Accumulator bit branch tests selected bit, adds operand when met.
// [RULE15] Zero-page bit branch tests first-operand byte, adds second operand.
// [RULE16] First byte is opcode; following bytes are address operands.
// [RULE17] Displacements signed, relative to next instruction; index sums carry.
`timescale 1ns/1ps
`default_nettype none
`include "eag_regs.svh"

module effective_address_generator #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8
) (
  input  wire logic                ref_clk_in,
  input  wire logic                resetn_in,
  input  wire logic                start_in,
  input  wire eag_pkg::mode_t      mode_in,
  input  wire logic [DATA_W-1:0]   opcode_in,
  input  wire logic [DATA_W-1:0]   operand1_in,
  input  wire logic [DATA_W-1:0]   operand2_in,
  input  wire logic [DATA_W-1:0]   x_in,
  input  wire logic [DATA_W-1:0]   y_in,
  input  wire logic [DATA_W-1:0]   acc_in,
  input  wire logic [ADDR_W-1:0]   pc_next_in,
  input  wire logic                cond_in,
  input  wire logic                bit_set_instr_in,
  input  wire logic                branch_if_bit_one_in,
  input  wire logic [DATA_W-1:0]   mem_rdata_in,
  output logic                     busy_out,
  output logic                     mem_rd_out,
  output logic      [ADDR_W-1:0]   mem_addr_out,
  output logic                     done_out,
  output logic      [ADDR_W-1:0]   data_addr_out,
  output logic                     data_addr_valid_out,
  output logic      [ADDR_W-1:0]   next_pc_out,
  output logic                     branch_taken_out,
  output logic                     implied_out,
  output logic      [DATA_W-1:0]   acc_out,
  output logic      [DATA_W-1:0]   bit_mask_out
);

  if (ADDR_W != 16 || DATA_W != 8) begin : g_bad_width
    $error("effective_address_generator serves only 16-bit addresses and 8-bit data");
  end

  // ----------------------------------------------------------------
  // Captured instruction
  // ----------------------------------------------------------------
  eag_pkg::state_t    state_q, state_d;
  eag_pkg::mode_t     mode_q;
  logic [DATA_W-1:0]  opc_q, op1_q, op2_q, y_q, acc_q, lo_q, hi_q;
  logic [ADDR_W-1:0]  pc_q, ptr_q;
  logic               cond_q, set_q, one_q;
  logic               busy_q, mem_rd_q, done_q, valid_q, taken_q, implied_q;
  logic [ADDR_W-1:0]  mem_addr_q, data_addr_q, next_pc_q;
  logic [DATA_W-1:0]  acc_res_q, mask_q;

  wire logic              start_take_w;
  wire logic              need_rd_w;
  wire logic              single_rd_w;
  wire logic [DATA_W-1:0] zp_index_w;
  wire logic [ADDR_W-1:0] ptr_start_w;
  wire logic [ADDR_W-1:0] ptr_hi_w;

  assign start_take_w = start_in && (state_q == eag_pkg::ST_IDLE);
  assign need_rd_w    = mode_in inside {eag_pkg::MODE_IND_X, eag_pkg::MODE_IND_Y, eag_pkg::MODE_IND_ABS,
                                        eag_pkg::MODE_ZP_IND, eag_pkg::MODE_ZP_BIT_REL};
  assign single_rd_w  = (mode_q == eag_pkg::MODE_ZP_BIT_REL);
  // Carry dropped so the pointer never leaves page zero
  assign zp_index_w   = 8'(operand1_in + x_in);  // [RULE5]
  assign ptr_start_w  = (mode_in == eag_pkg::MODE_IND_X)   ? {`EAG_ZERO_PAGE_HI, zp_index_w} :  // [RULE5]
                        (mode_in == eag_pkg::MODE_IND_ABS) ? {operand2_in, operand1_in} :       // [RULE8]
                        {`EAG_ZERO_PAGE_HI, operand1_in};                             // [RULE7] [RULE10] [RULE15]
  // Page-end pointers of an indirect jump are left to software; full 16-bit step here
  assign ptr_hi_w     = (mode_q == eag_pkg::MODE_IND_ABS) ? ptr_q + `EAG_PTR_STEP16 :  // [RULE8] [RULE9]
                        {`EAG_ZERO_PAGE_HI, 8'(ptr_q[7:0] + `EAG_PTR_STEP8)};          // [RULE6] [RULE10]

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      eag_pkg::ST_IDLE:  if (start_in) state_d = need_rd_w ? eag_pkg::ST_RD_LO : eag_pkg::ST_FIN;
      eag_pkg::ST_RD_LO: state_d = eag_pkg::ST_WT_LO;
      eag_pkg::ST_WT_LO: state_d = single_rd_w ? eag_pkg::ST_FIN : eag_pkg::ST_RD_HI;
      eag_pkg::ST_RD_HI: state_d = eag_pkg::ST_WT_HI;
      eag_pkg::ST_WT_HI: state_d = eag_pkg::ST_FIN;
      eag_pkg::ST_FIN:   state_d = eag_pkg::ST_IDLE;
    endcase
  end

  wire logic              mem_rd_d;
  wire logic [ADDR_W-1:0] mem_addr_d;

  assign mem_rd_d   = (state_d == eag_pkg::ST_RD_LO) || (state_d == eag_pkg::ST_RD_HI);
  assign mem_addr_d = (state_d == eag_pkg::ST_RD_LO) ? ptr_start_w :
                      (state_d == eag_pkg::ST_RD_HI) ? ptr_hi_w : mem_addr_q;

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q    <= eag_pkg::ST_IDLE;
      busy_q     <= 1'b0;
      mem_rd_q   <= 1'b0;
      mem_addr_q <= `EAG_ADDR_RST;
      lo_q       <= `EAG_DATA_RST;
      hi_q       <= `EAG_DATA_RST;
    end else begin
      state_q    <= state_d;
      busy_q     <= (state_d != eag_pkg::ST_IDLE);
      mem_rd_q   <= mem_rd_d;
      mem_addr_q <= mem_addr_d;
      if (state_q == eag_pkg::ST_WT_LO) lo_q <= mem_rdata_in;  // [RULE6] [RULE7] [RULE15]
      if (state_q == eag_pkg::ST_WT_HI) hi_q <= mem_rdata_in;  // [RULE6] [RULE8] [RULE10]
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_q <= eag_pkg::MODE_IMPLIED;
      opc_q  <= `EAG_DATA_RST;
      op1_q  <= `EAG_DATA_RST;
      op2_q  <= `EAG_DATA_RST;
      y_q    <= `EAG_DATA_RST;
      acc_q  <= `EAG_DATA_RST;
      pc_q   <= `EAG_ADDR_RST;
      ptr_q  <= `EAG_ADDR_RST;
      cond_q <= 1'b0;
      set_q  <= 1'b0;
      one_q  <= 1'b0;
    end else if (start_take_w) begin
      mode_q <= mode_in;
      opc_q  <= opcode_in;    // [RULE16]
      op1_q  <= operand1_in;  // [RULE16]
      op2_q  <= operand2_in;  // [RULE16]
      y_q    <= y_in;
      acc_q  <= acc_in;
      pc_q   <= pc_next_in;
      ptr_q  <= ptr_start_w;
      cond_q <= cond_in;
      set_q  <= bit_set_instr_in;
      one_q  <= branch_if_bit_one_in;
    end
  end

  // ----------------------------------------------------------------
  // Address and target formation
  // ----------------------------------------------------------------
  wire logic [2:0]        bit_idx_w;
  wire logic [DATA_W-1:0] mask_w;
  wire logic [ADDR_W-1:0] idx_base_w, idx_sum_w, br_sum_w, ptr_data_w;
  wire logic [DATA_W-1:0] br_disp_w, acc_mod_w;
  wire logic              bit_val_w, taken_w, is_bit_w, valid_w;
  wire logic [ADDR_W-1:0] next_pc_w, data_addr_w;

  assign bit_idx_w  = opc_q[`EAG_BITNUM_MSB:`EAG_BITNUM_LSB];  // [RULE12] [RULE13] [RULE14]
  assign mask_w     = `EAG_ONE_BIT_MASK << bit_idx_w;
  assign ptr_data_w = {hi_q, lo_q};
  assign idx_base_w = (mode_q == eag_pkg::MODE_IND_Y) ? ptr_data_w : {op2_q, op1_q};  // [RULE1] [RULE7]
  assign br_disp_w  = (mode_q == eag_pkg::MODE_ZP_BIT_REL) ? op2_q : op1_q;           // [RULE15]

  ea_adder #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_idx_add (
    .base_in   (idx_base_w),
    .offset_in (y_q),
    .signed_in (1'b0),
    .sum_out   (idx_sum_w)
  );  // [RULE17]

  ea_adder #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_br_add (
    .base_in   (pc_q),
    .offset_in (br_disp_w),
    .signed_in (1'b1),
    .sum_out   (br_sum_w)
  );  // [RULE17]

  assign bit_val_w = (mode_q == eag_pkg::MODE_ZP_BIT_REL) ? lo_q[bit_idx_w] : acc_q[bit_idx_w];
  assign taken_w   = (mode_q == eag_pkg::MODE_REL) ? cond_q :                       // [RULE3]
                     (mode_q inside {eag_pkg::MODE_ACC_BIT_REL, eag_pkg::MODE_ZP_BIT_REL}) ?
                     (bit_val_w == one_q) : 1'b0;                                   // [RULE14] [RULE15]
  assign next_pc_w = taken_w ? br_sum_w :                                           // [RULE3]
                     (mode_q inside {eag_pkg::MODE_IND_ABS, eag_pkg::MODE_ZP_IND}) ? ptr_data_w :  // [RULE8]
                     (mode_q == eag_pkg::MODE_SPECIAL) ? {`EAG_SPECIAL_PAGE_HI, op1_q} :           // [RULE11]
                     pc_q;                                                          // [RULE4]
  assign data_addr_w = (mode_q inside {eag_pkg::MODE_ABS_Y, eag_pkg::MODE_IND_Y}) ? idx_sum_w :   // [RULE1]
                       (mode_q == eag_pkg::MODE_IND_X) ? ptr_data_w :                              // [RULE6]
                       (mode_q == eag_pkg::MODE_ZP_BIT) ? {`EAG_ZERO_PAGE_HI, op1_q} :             // [RULE12]
                       `EAG_ADDR_RST;
  assign valid_w   = mode_q inside {eag_pkg::MODE_ABS_Y, eag_pkg::MODE_IND_Y, eag_pkg::MODE_IND_X,
                                    eag_pkg::MODE_ZP_BIT};
  assign is_bit_w  = mode_q inside {eag_pkg::MODE_ZP_BIT, eag_pkg::MODE_ACC_BIT,
                                    eag_pkg::MODE_ACC_BIT_REL, eag_pkg::MODE_ZP_BIT_REL};
  assign acc_mod_w = (mode_q != eag_pkg::MODE_ACC_BIT) ? acc_q :
                     set_q ? (acc_q | mask_w) : (acc_q & ~mask_w);  // [RULE13]

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      done_q      <= 1'b0;
      valid_q     <= 1'b0;
      taken_q     <= 1'b0;
      implied_q   <= 1'b0;
      data_addr_q <= `EAG_ADDR_RST;
      next_pc_q   <= `EAG_ADDR_RST;
      acc_res_q   <= `EAG_DATA_RST;
      mask_q      <= `EAG_DATA_RST;
    end else begin
      done_q <= (state_q == eag_pkg::ST_FIN);
      if (state_q == eag_pkg::ST_FIN) begin
        valid_q     <= valid_w;
        taken_q     <= taken_w;
        implied_q   <= (mode_q == eag_pkg::MODE_IMPLIED);  // [RULE2]
        data_addr_q <= data_addr_w;
        next_pc_q   <= next_pc_w;
        acc_res_q   <= acc_mod_w;
        mask_q      <= is_bit_w ? mask_w : `EAG_DATA_RST;
      end
    end
  end

  assign busy_out            = busy_q;
  assign mem_rd_out          = mem_rd_q;
  assign mem_addr_out        = mem_addr_q;
  assign done_out            = done_q;
  assign data_addr_out       = data_addr_q;
  assign data_addr_valid_out = valid_q;
  assign next_pc_out         = next_pc_q;
  assign branch_taken_out    = taken_q;
  assign implied_out         = implied_q;
  assign acc_out             = acc_res_q;
  assign bit_mask_out        = mask_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  wire logic [ADDR_W-1:0] absy_ref_w = 16'({op2_q, op1_q} + {8'h00, y_q});
  wire logic [ADDR_W-1:0] indy_ref_w = 16'(ptr_data_w + {8'h00, y_q});
  wire logic [ADDR_W-1:0] rel_ref_w  = 16'(pc_q + {{8{op1_q[7]}}, op1_q});

  sequence s_fin(eag_pkg::mode_t m);
    state_q == eag_pkg::ST_FIN && mode_q == m;
  endsequence

  sequence s_ptr_pair;
    mem_rd_out ##1 !mem_rd_out ##1 mem_rd_out;
  endsequence

  property p_absy;   s_fin(eag_pkg::MODE_ABS_Y) |=> done_out && data_addr_out == $past(absy_ref_w); endproperty
  property p_impl;   s_fin(eag_pkg::MODE_IMPLIED) |=> implied_out && !data_addr_valid_out; endproperty
  property p_rel;    s_fin(eag_pkg::MODE_REL) ##0 cond_q |=> next_pc_out == $past(rel_ref_w); endproperty
  property p_untaken;
    state_q == eag_pkg::ST_FIN && !taken_w && (mode_q inside {eag_pkg::MODE_REL, eag_pkg::MODE_ACC_BIT_REL,
    eag_pkg::MODE_ZP_BIT_REL}) |=> !branch_taken_out && next_pc_out == $past(pc_q);
  endproperty
  property p_indx_ptr;
    start_take_w && mode_in == eag_pkg::MODE_IND_X |=>
      mem_rd_out && mem_addr_out == {8'h00, 8'($past(operand1_in) + $past(x_in))} ##0 s_ptr_pair;
  endproperty
  property p_zp_hi;
    mem_rd_out && state_q == eag_pkg::ST_RD_HI && mode_q != eag_pkg::MODE_IND_ABS |->
      mem_addr_out == {`EAG_ZERO_PAGE_HI, 8'(ptr_q[7:0] + `EAG_PTR_STEP8)};
  endproperty
  property p_indy;   s_fin(eag_pkg::MODE_IND_Y) |=> data_addr_out == $past(indy_ref_w); endproperty
  property p_indabs_hi;
    mem_rd_out && state_q == eag_pkg::ST_RD_HI && mode_q == eag_pkg::MODE_IND_ABS |-> mem_addr_out == 16'(ptr_q + 16'h0001);
  endproperty
  property p_special; s_fin(eag_pkg::MODE_SPECIAL) |=> next_pc_out == {8'hff, $past(op1_q)}; endproperty
  property p_zpbit;
    s_fin(eag_pkg::MODE_ZP_BIT) |=> data_addr_out == {8'h00, $past(op1_q)} &&
      bit_mask_out == (8'h01 << $past(opc_q[7:5]));
  endproperty
  // Bit already at its target level leaves the accumulator unchanged
  property p_accbit;
    s_fin(eag_pkg::MODE_ACC_BIT) |=> acc_out == ($past(set_q) ? ($past(acc_q) | (8'h01 << $past(opc_q[7:5]))) :
                                                 ($past(acc_q) & ~(8'h01 << $past(opc_q[7:5]))));
  endproperty
  property p_accrel;
    s_fin(eag_pkg::MODE_ACC_BIT_REL) ##0 (acc_q[bit_idx_w] == one_q) |=> branch_taken_out;
  endproperty
  property p_zprel_len;
    start_take_w && mode_in == eag_pkg::MODE_ZP_BIT_REL |=> mem_rd_out ##1 !mem_rd_out ##1 !mem_rd_out ##1 done_out;
  endproperty

  a_absy:      assert property (p_absy)      else $error("abs-y address wrong");          // [RULE1]
  a_impl:      assert property (p_impl)      else $error("implied gave an address");      // [RULE2]
  a_rel:       assert property (p_rel)       else $error("relative target wrong");        // [RULE3]
  a_untaken:   assert property (p_untaken)   else $error("untaken branch moved pc");      // [RULE4]
  a_indx_ptr:  assert property (p_indx_ptr)  else $error("pre-indexed pointer wrong");    // [RULE5]
  a_zp_hi:     assert property (p_zp_hi)     else $error("zero-page high read wrong");    // [RULE6]
  a_indy:      assert property (p_indy)      else $error("post-indexed address wrong");   // [RULE7]
  a_indabs_hi: assert property (p_indabs_hi) else $error("indirect high read wrong");     // [RULE8]
  a_special:   assert property (p_special)   else $error("special page target wrong");    // [RULE11]
  a_zpbit:     assert property (p_zpbit)     else $error("zero-page bit wrong");          // [RULE12]
  a_accbit:    assert property (p_accbit)    else $error("accumulator bit op wrong");     // [RULE13]
  a_accrel:    assert property (p_accrel)    else $error("acc bit branch not taken");     // [RULE14]
  a_zprel_len: assert property (p_zprel_len) else $error("zp bit branch sequence wrong"); // [RULE15]

endmodule : effective_address_generator

`default_nettype wire

// [bench/mem_model.sv]
// Memory model on the far side of the address generator: one-cycle read latency.
// Assumes a one-cycle strobe and data sampled in the cycle after it.
`timescale 1ns/1ps
`default_nettype none

module mem_model (
  input  wire logic        ref_clk_in,
  input  wire logic        resetn_in,
  input  wire logic        mem_rd_in,
  input  wire logic [15:0] mem_addr_in,
  output logic      [7:0]  mem_rdata_out
);
  // Address hash: neighbouring bytes always differ
  function automatic logic [7:0] content(input logic [15:0] a);
    return a[7:0] * 8'h1d ^ a[15:8] ^ 8'h5a;
  endfunction : content

  // Bus toggles outside the answer cycle, so stale data never looks valid
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mem_rdata_out <= 8'h00;
    end else if (mem_rd_in) begin
      mem_rdata_out <= content(mem_addr_in);
    end else begin
      mem_rdata_out <= ~mem_rdata_out;
    end
  end
endmodule : mem_model

`default_nettype wire

// [bench/tb_effective_address_generator.sv]
// Self-checking bench of the address generator: corner sweep over every mode, then random ops.
// Assumes mem_model answers reads; expectations are rebuilt here from operands and memory.
`timescale 1ns/1ps
`default_nettype none

module tb_effective_address_generator;
  logic           ref_clk_in, resetn_in, start_in, cond_in, bit_set_instr_in, branch_if_bit_one_in;
  eag_pkg::mode_t mode_in, m;
  logic [7:0]     opcode_in, operand1_in, operand2_in, x_in, y_in, acc_in, mem_rdata, acc_out, bit_mask_out;
  logic [15:0]    pc_next_in, mem_addr_out, data_addr_out, next_pc_out, pc;
  logic           busy_out, mem_rd_out, done_out, data_addr_valid_out, branch_taken_out, implied_out;
  logic [7:0]     opc, o1, o2, xv, yv, av;
  logic           c, bs, bo;
  logic [15:0]    addr_q[$];
  logic [31:0]    seed = 32'h00000021;
  logic [7:0]     corner_v [4] = '{8'hff, 8'h80, 8'h7f, 8'h00};
  int             err_total = 0, checked = 0, cycles = 0;

  effective_address_generator u_effective_address_generator (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .start_in(start_in), .mode_in(mode_in),
    .opcode_in(opcode_in), .operand1_in(operand1_in), .operand2_in(operand2_in), .x_in(x_in),
    .y_in(y_in), .acc_in(acc_in), .pc_next_in(pc_next_in), .cond_in(cond_in),
    .bit_set_instr_in(bit_set_instr_in), .branch_if_bit_one_in(branch_if_bit_one_in),
    .mem_rdata_in(mem_rdata), .busy_out(busy_out), .mem_rd_out(mem_rd_out), .mem_addr_out(mem_addr_out),
    .done_out(done_out), .data_addr_out(data_addr_out), .data_addr_valid_out(data_addr_valid_out),
    .next_pc_out(next_pc_out), .branch_taken_out(branch_taken_out), .implied_out(implied_out),
    .acc_out(acc_out), .bit_mask_out(bit_mask_out));

  mem_model u_mem_model (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .mem_rd_in(mem_rd_out),
    .mem_addr_in(mem_addr_out), .mem_rdata_out(mem_rdata));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  task automatic rand_stim(input eag_pkg::mode_t mm);
    logic [31:0] r1, r2, r3;
    r1 = xs();
    r2 = xs();
    r3 = xs();
    m = mm;
    {opc, o1, o2, xv} = r1;
    {yv, av, pc} = r2;
    {c, bs, bo} = r3[2:0];
    if (m == eag_pkg::MODE_IND_ABS && o1 == 8'hff) o1 = 8'hfe;
  endtask : rand_stim

  // ---------------------------------------------------------------
  // One operation: drive, scramble inputs while busy, then compare
  // ---------------------------------------------------------------
  task automatic run_op();
    logic [15:0] e_pc, e_da, la, ha;
    logic [7:0]  lo, hi, mk, e_mk, e_acc, d;
    logic [31:0] r1, r2;
    logic        e_tk, e_dv, bt, is_br;
    int          lat, n, nrd;
    la = (m == eag_pkg::MODE_IND_X) ? {8'h00, o1 + xv} : (m == eag_pkg::MODE_IND_ABS) ? {o2, o1} : {8'h00, o1};
    ha = (m == eag_pkg::MODE_IND_ABS) ? la + 16'h0001 : {8'h00, la[7:0] + 8'h01};
    lo = u_mem_model.content(la);
    hi = u_mem_model.content(ha);
    bt = (m == eag_pkg::MODE_ZP_BIT_REL) ? lo[opc[7:5]] : av[opc[7:5]];
    d = (m == eag_pkg::MODE_ZP_BIT_REL) ? o2 : o1;
    mk = 8'h01 << opc[7:5];
    is_br = m inside {eag_pkg::MODE_REL, eag_pkg::MODE_ACC_BIT_REL, eag_pkg::MODE_ZP_BIT_REL};
    e_pc = pc;
    e_da = {8'h00, o1};
    e_tk = (m == eag_pkg::MODE_REL) ? c : (bt == bo);
    e_dv = m inside {eag_pkg::MODE_ABS_Y, eag_pkg::MODE_IND_X, eag_pkg::MODE_IND_Y, eag_pkg::MODE_ZP_BIT};
    e_mk = m inside {eag_pkg::MODE_ZP_BIT, eag_pkg::MODE_ACC_BIT, eag_pkg::MODE_ACC_BIT_REL,
                     eag_pkg::MODE_ZP_BIT_REL} ? mk : 8'h00;
    e_acc = (m != eag_pkg::MODE_ACC_BIT) ? av : bs ? (av | mk) : (av & ~mk);
    nrd = m inside {eag_pkg::MODE_IND_X, eag_pkg::MODE_IND_Y, eag_pkg::MODE_IND_ABS, eag_pkg::MODE_ZP_IND} ? 2 : 0;
    if (m == eag_pkg::MODE_ZP_BIT_REL) nrd = 1;
    lat = (nrd == 2) ? 6 : (nrd == 1) ? 4 : 2;
    if (m == eag_pkg::MODE_ABS_Y) e_da = {o2, o1} + {8'h00, yv};
    if (m == eag_pkg::MODE_IND_X) e_da = {hi, lo};
    if (m == eag_pkg::MODE_IND_Y) e_da = {hi, lo} + {8'h00, yv};
    if (m inside {eag_pkg::MODE_IND_ABS, eag_pkg::MODE_ZP_IND}) e_pc = {hi, lo};
    if (m == eag_pkg::MODE_SPECIAL) e_pc = {8'hff, o1};
    if (is_br && e_tk) e_pc = pc + {{8{d[7]}}, d};
    @(posedge ref_clk_in);
    addr_q.delete();
    start_in <= 1'b1;
    mode_in <= m;
    {opcode_in, operand1_in, operand2_in, x_in, y_in, acc_in, pc_next_in} <= {opc, o1, o2, xv, yv, av, pc};
    {cond_in, bit_set_instr_in, branch_if_bit_one_in} <= {c, bs, bo};
    @(posedge ref_clk_in);
    // Garbage while busy; a held start here must be ignored
    r1 = xs();
    r2 = xs();
    start_in <= r2[31];
    mode_in <= eag_pkg::mode_t'(r2[30:28]);
    {opcode_in, operand1_in, operand2_in, x_in} <= r1;
    {y_in, acc_in, pc_next_in} <= xs();
    {cond_in, bit_set_instr_in, branch_if_bit_one_in} <= r2[2:0];
    #1;
    check("busy", busy_out, 1'b1);
    n = 0;
    do begin
      @(posedge ref_clk_in);
      start_in <= 1'b0;
      n++;
      #1;
    end while (done_out !== 1'b1 && n < 8);
    check("latency", n, lat - 1);
    check("busy at done", busy_out, 1'b0);
    check("next pc", next_pc_out, e_pc);
    check("taken", branch_taken_out, is_br && e_tk);
    check("implied", implied_out, m == eag_pkg::MODE_IMPLIED);
    check("acc", acc_out, e_acc);
    check("mask", bit_mask_out, e_mk);
    if (m != eag_pkg::MODE_ZP_BIT_REL) check("data valid", data_addr_valid_out, e_dv);
    if (e_dv) check("data addr", data_addr_out, e_da);
    check("reads", addr_q.size(), nrd);
    if (nrd > 0) check("ptr lo", addr_q[0], la);
    if (nrd > 1) check("ptr hi", addr_q[1], ha);
  endtask : run_op

  always @(posedge ref_clk_in) begin
    if (mem_rd_out === 1'b1) addr_q.push_back(mem_addr_out);
  end

  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end

  initial begin
    forever begin
      @(posedge ref_clk_in);
      cycles++;
      if (cycles == 20000) begin
        err_total++;
        wrap_up();
      end
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    resetn_in = 1'b0;
    start_in = 1'b0;
    mode_in = eag_pkg::MODE_ABS_Y;
    {opcode_in, operand1_in, operand2_in, x_in, y_in, acc_in, pc_next_in} = '0;
    {cond_in, bit_set_instr_in, branch_if_bit_one_in} = 3'h0;
    repeat (4) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    @(posedge ref_clk_in);
    #1;
    check("reset done", done_out, 1'b0);
    check("reset pc", next_pc_out, 16'h0000);
    // Page ends, sign boundaries and index carries in every mode, except a page-end pointer for the indirect jump
    for (int i = 0; i < 48; i++) begin
      rand_stim(eag_pkg::mode_t'(i % 12));
      o1 = corner_v[i / 12];
      xv = corner_v[(i / 12 + 1) % 4];
      yv = xv;
      if (m == eag_pkg::MODE_IND_ABS && o1 == 8'hff) o1 = 8'hfe;
      run_op();
    end
    $display("test corners done");
    // Reset in mid-run must clear the results of the last operation
    @(posedge ref_clk_in);
    resetn_in <= 1'b0;
    @(posedge ref_clk_in);
    #1;
    check("mid reset done", done_out, 1'b0);
    check("mid reset pc", next_pc_out, 16'h0000);
    check("mid reset mask", bit_mask_out, 8'h00);
    check("mid reset busy", busy_out, 1'b0);
    @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    $display("test mid reset done");
    for (int i = 0; i < 400; i++) begin
      rand_stim(eag_pkg::mode_t'(xs() % 12));
      run_op();
    end
    $display("test random done");
    wrap_up();
  end
endmodule : tb_effective_address_generator

`default_nettype wire
